// ### src/config_register_access_unit.sv
// Host-facing configuration register access unit
module config_register_access_unit
    import cfg_access_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Host I/O port bus
    input  wire logic [9:0] io_addr,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_data_in,
    output logic      [7:0] io_data_out,
    output logic            io_data_oe,
    // Hardware straps
    input  wire logic       strap_key_select,
    input  wire logic       strap_alt_port,
    // Mode and lock status
    output logic            extended_mode,
    output logic            config_lock,
    // Parallel port control
    output logic      [2:0] parport_mode,
    output logic            external_floppy_ctrl_mode,
    output logic            dual_external_floppy_mode,
    output logic            parport_mode_reserved,
    output logic            epp_version_select,
    // Power, floppy and UART control
    output logic            immediate_powerdown,
    output logic            floppy_drive_swap,
    output logic      [3:0] uart_a_clock_divisor,
    output logic      [3:0] uart_b_clock_divisor
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    cfg_store_if store_bus ();      // Link to generic storage

    logic [7:0] cr0, next_cr0;      // Parallel mode and powerdown
    logic [7:0] cr1, next_cr1;      // Floppy swap
    logic [7:0] cr3, next_cr3;      // EPP and UART clocks
    logic [7:0] cr9, next_cr9;      // Lock and mode high bit
    logic [7:0] index, next_index;  // Selected register index
    logic       key_select;         // Entry key select
    logic       next_key_select;
    logic       alt_port;           // Alternate port select
    logic       next_alt_port;
    logic       strap_pending;      // Straps not yet captured
    logic       rd_pending;         // Data port read in flight
    logic       next_rd_pending;
    logic       rd_valid_index;     // Pending read hits known index
    logic       next_rd_valid_index;
    logic [7:0] next_io_data_out;
    logic       next_io_data_oe;
    logic       ext_mode;           // Sequencer mode flag
    logic [2:0] next_mode_code;     // Combined parallel mode

    // Port decode
    logic [9:0] enable_port;        // Key port in force
    logic [9:0] data_port;          // Data port in force
    logic       key_port_wr;        // Write to key port
    logic       index_wr;           // Write to index port
    logic       data_wr;            // Accepted data port write
    logic       data_rd;            // Data port read
    logic       lock_ok;            // Write permitted by lock
    logic [7:0] read_byte;          // Byte offered to host

    // ------------------------------------------------------------
    // Entry sequencer and storage
    // ------------------------------------------------------------
    key_matcher u_key_matcher (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .key_port_wr (key_port_wr),
        .other_wr    (io_wr && !key_port_wr),
        .wr_data     (io_data_in),
        .key_select  (key_select),
        .alt_port    (alt_port),
        .ext_mode    (ext_mode)
    );

    cfg_store #(
        .DEPTH (CONFIG_SPACE_DEPTH)
    ) u_cfg_store (
        .clock   (clock),
        .sys_rst (sys_rst),
        .bus     (store_bus)
    );

    // ------------------------------------------------------------
    // Host port decode
    // ------------------------------------------------------------

    // Ports follow the alternate select
    always_comb begin
        enable_port = alt_port ? ALT_UNLOCK_AND_INDEX_PORT : UNLOCK_KEY_PORT;
        data_port   = alt_port ? ALT_CONFIG_DATA_PORT : CONFIG_DATA_PORT;
        key_port_wr = io_wr && io_addr == enable_port && !strap_pending;
        // Index shares the key port on the alternate address
        if (alt_port) begin
            index_wr = ext_mode && key_port_wr && io_data_in != ALT_EXIT_KEY;
        end else begin
            index_wr = ext_mode && io_wr && io_addr == CONFIG_INDEX_PORT;
        end
        lock_ok = !cr9[CONFIG_LOCK_BIT] || index == CONFIG_REG_NINE;
        data_wr = ext_mode && io_wr && io_addr == data_port
                  && index_recognised(index) && lock_ok;
        data_rd = ext_mode && io_rd && io_addr == data_port;
    end

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------

    // Next values of the dedicated registers
    always_comb begin
        next_cr0        = cr0;
        next_cr1        = cr1;
        next_cr3        = cr3;
        next_cr9        = cr9;
        next_key_select = key_select;
        next_alt_port   = alt_port;
        next_index      = index_wr ? io_data_in : index;
        store_bus.wr_en = 1'b0;
        store_bus.addr  = index[6:0];
        store_bus.wdata = io_data_in;
        if (strap_pending) begin
            next_key_select = strap_key_select;
            next_alt_port   = strap_alt_port;
        end else if (data_wr) begin
            case (index)
                PARALLEL_MODE_AND_POWERDOWN:
                    next_cr0 = masked_write(cr0, io_data_in, CR0_MASK);
                FLOPPY_SWAP_CONTROL:
                    next_cr1 = masked_write(cr1, io_data_in, CR1_MASK);
                RESERVED_CONFIG_TWO: begin
                    // Whole register ignored
                    next_cr0 = cr0;
                end
                EPP_AND_UART_CLOCK_SELECT:
                    next_cr3 = masked_write(cr3, io_data_in, CR3_MASK);
                CONFIG_REG_NINE:
                    next_cr9 = masked_write(cr9, io_data_in, CR9_MASK);
                KEY_SELECT_REG: begin
                    next_key_select = io_data_in[ENTRY_KEY_SELECT_BIT];
                    store_bus.wr_en = 1'b1;
                end
                ALT_PORT_REG: begin
                    next_alt_port   = io_data_in[ALT_PORT_SELECT_BIT];
                    store_bus.wr_en = 1'b1;
                end
                default: store_bus.wr_en = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------

    // Byte returned for the current index
    always_comb begin
        case (index)
            PARALLEL_MODE_AND_POWERDOWN: read_byte = cr0;
            FLOPPY_SWAP_CONTROL:         read_byte = cr1;
            RESERVED_CONFIG_TWO:         read_byte = CR2_RESET;
            EPP_AND_UART_CLOCK_SELECT:   read_byte = cr3;
            CONFIG_REG_NINE:             read_byte = cr9;
            KEY_SELECT_REG: begin
                read_byte = store_bus.rdata;
                read_byte[ENTRY_KEY_SELECT_BIT] = key_select;
            end
            ALT_PORT_REG: begin
                read_byte = store_bus.rdata;
                read_byte[ALT_PORT_SELECT_BIT] = alt_port;
            end
            default: read_byte = store_bus.rdata;
        endcase
        next_rd_pending     = data_rd;
        next_rd_valid_index = data_rd && index_recognised(index);
        next_io_data_oe     = rd_pending;
        next_io_data_out    = rd_valid_index ? read_byte : 8'h00;
    end

    // ------------------------------------------------------------
    // Derived control outputs
    // ------------------------------------------------------------

    // Decode of the next register contents
    always_comb begin
        next_mode_code = {next_cr9[PARPORT_MODE_HIGH_BIT],
                          next_cr0[PARPORT_MODE_MID_BIT],
                          next_cr0[PARPORT_MODE_LOW_BIT]};
    end

    // ------------------------------------------------------------
    // Registers, restored only by the cold reset
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            cr0                       <= CR0_RESET;
            cr1                       <= CR1_RESET;
            cr3                       <= CR3_RESET;
            cr9                       <= CR9_RESET;
            index                     <= 8'h00;
            key_select                <= KEY_SELECT_RESET;
            alt_port                  <= ALT_PORT_RESET;
            strap_pending             <= 1'b1;
            rd_pending                <= 1'b0;
            rd_valid_index            <= 1'b0;
            io_data_out               <= 8'h00;
            io_data_oe                <= 1'b0;
            extended_mode             <= 1'b0;
            config_lock               <= 1'b0;
            parport_mode              <= PARPORT_NORMAL;
            external_floppy_ctrl_mode <= 1'b0;
            dual_external_floppy_mode <= 1'b0;
            parport_mode_reserved     <= 1'b0;
            epp_version_select        <= CR3_RESET[EPP_VERSION_SELECT_BIT];
            immediate_powerdown       <= 1'b0;
            floppy_drive_swap         <= 1'b0;
            uart_a_clock_divisor      <= UART_DIV_STANDARD;
            uart_b_clock_divisor      <= UART_DIV_STANDARD;
        end else begin
            cr0                       <= next_cr0;
            cr1                       <= next_cr1;
            cr3                       <= next_cr3;
            cr9                       <= next_cr9;
            index                     <= next_index;
            key_select                <= next_key_select;
            alt_port                  <= next_alt_port;
            strap_pending             <= 1'b0;
            rd_pending                <= next_rd_pending;
            rd_valid_index            <= next_rd_valid_index;
            io_data_out               <= next_io_data_out;
            io_data_oe                <= next_io_data_oe;
            extended_mode             <= ext_mode;
            config_lock               <= next_cr9[CONFIG_LOCK_BIT];
            parport_mode              <= next_mode_code;
            external_floppy_ctrl_mode <= next_mode_code == PARPORT_EXT_FDC;
            dual_external_floppy_mode <= next_mode_code == PARPORT_DUAL_EXT_FDD;
            parport_mode_reserved     <= next_mode_code == PARPORT_RESERVED_LOW
                                         || next_mode_code == PARPORT_RESERVED_HI;
            epp_version_select        <= next_cr3[EPP_VERSION_SELECT_BIT];
            immediate_powerdown       <= next_cr0[IMMEDIATE_POWERDOWN_BIT];
            floppy_drive_swap         <= next_cr1[FLOPPY_DRIVE_SWAP_BIT];
            uart_a_clock_divisor      <= next_cr3[UART_A_MIDI_BIT]
                                         ? UART_DIV_MIDI : UART_DIV_STANDARD;
            uart_b_clock_divisor      <= next_cr3[UART_B_MIDI_BIT]
                                         ? UART_DIV_MIDI : UART_DIV_STANDARD;
        end
    end

endmodule // config_register_access_unit

// ### src/cfg_access_pkg.sv
// Shared constants, types and decode helpers of the configuration access unit
package cfg_access_pkg;

    // ------------------------------------------------------------
    // Host I/O port addresses
    // ------------------------------------------------------------
    localparam logic [9:0] UNLOCK_KEY_PORT           = 10'h250;
    localparam logic [9:0] CONFIG_INDEX_PORT         = 10'h251;
    localparam logic [9:0] CONFIG_DATA_PORT          = 10'h252;
    localparam logic [9:0] ALT_UNLOCK_AND_INDEX_PORT = 10'h3f0;
    localparam logic [9:0] ALT_CONFIG_DATA_PORT      = 10'h3f1;

    // ------------------------------------------------------------
    // Entry and exit key values
    // ------------------------------------------------------------
    localparam logic [7:0] PRIMARY_KEY_LOW  = 8'h88;
    localparam logic [7:0] PRIMARY_KEY_HIGH = 8'h89;
    localparam logic [7:0] ALT_KEY_LOW      = 8'h86;
    localparam logic [7:0] ALT_KEY_HIGH     = 8'h87;
    localparam logic [7:0] ALT_EXIT_KEY     = 8'haa;

    // ------------------------------------------------------------
    // Configuration register indices
    // ------------------------------------------------------------
    localparam logic [7:0] PARALLEL_MODE_AND_POWERDOWN = 8'h00;
    localparam logic [7:0] FLOPPY_SWAP_CONTROL         = 8'h01;
    localparam logic [7:0] RESERVED_CONFIG_TWO         = 8'h02;
    localparam logic [7:0] EPP_AND_UART_CLOCK_SELECT   = 8'h03;
    localparam logic [7:0] CONFIG_REG_NINE             = 8'h09;
    localparam logic [7:0] KEY_SELECT_REG              = 8'h0c;
    localparam logic [7:0] ALT_PORT_REG                = 8'h16;

    // ------------------------------------------------------------
    // Reset values and writable-bit masks
    // ------------------------------------------------------------
    localparam logic [7:0] CR0_RESET  = 8'h00;
    localparam logic [7:0] CR1_RESET  = 8'h00;
    localparam logic [7:0] CR2_RESET  = 8'h00;
    localparam logic [7:0] CR3_RESET  = 8'h30;
    localparam logic [7:0] CR9_RESET  = 8'h00;
    localparam logic [7:0] CR0_MASK   = 8'h0d;
    localparam logic [7:0] CR1_MASK   = 8'h80;
    localparam logic [7:0] CR3_MASK   = 8'h23;
    localparam logic [7:0] CR9_MASK   = 8'hff;
    localparam logic       KEY_SELECT_RESET = 1'b1;
    localparam logic       ALT_PORT_RESET   = 1'b0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int IMMEDIATE_POWERDOWN_BIT = 0;
    localparam int PARPORT_MODE_LOW_BIT    = 2;
    localparam int PARPORT_MODE_MID_BIT    = 3;
    localparam int FLOPPY_DRIVE_SWAP_BIT   = 7;
    localparam int EPP_VERSION_SELECT_BIT  = 5;
    localparam int UART_A_MIDI_BIT         = 1;
    localparam int UART_B_MIDI_BIT         = 0;
    localparam int CONFIG_LOCK_BIT         = 6;
    localparam int PARPORT_MODE_HIGH_BIT   = 7;
    localparam int ENTRY_KEY_SELECT_BIT    = 5;
    localparam int ALT_PORT_SELECT_BIT     = 0;

    // ------------------------------------------------------------
    // Parallel port mode codes and UART divisors
    // ------------------------------------------------------------
    localparam logic [2:0] PARPORT_NORMAL       = 3'h0;
    localparam logic [2:0] PARPORT_EXT_FDC      = 3'h1;
    localparam logic [2:0] PARPORT_RESERVED_LOW = 3'h2;
    localparam logic [2:0] PARPORT_DUAL_EXT_FDD = 3'h3;
    localparam logic [2:0] PARPORT_RESERVED_HI  = 3'h4;
    localparam int         UART_SOURCE_MHZ      = 24;
    localparam logic [3:0] UART_DIV_STANDARD    = 4'hd;
    localparam logic [3:0] UART_DIV_MIDI        = 4'hc;

    // Size of the generic configuration space
    localparam int CONFIG_SPACE_DEPTH = 70;

    // Entry sequence states
    typedef enum logic [1:0] {KEY_IDLE, KEY_HALF, KEY_EXT} key_state_t;

    // Index ranges the decoder recognises
    function automatic logic index_recognised(input logic [7:0] idx);
        index_recognised = (idx <= 8'h19)
            || (idx >= 8'h20 && idx <= 8'h29)
            || (idx >= 8'h2c && idx <= 8'h2d)
            || (idx >= 8'h31 && idx <= 8'h3a)
            || (idx >= 8'h40 && idx <= 8'h45);
    endfunction

    // Merge a host byte into a register through its writable mask
    function automatic logic [7:0] masked_write(input logic [7:0] old_val,
                                                input logic [7:0] new_val,
                                                input logic [7:0] mask);
        masked_write = (old_val & ~mask) | (new_val & mask);
    endfunction

endpackage

// ### src/cfg_store_if.sv
// Carrier between the access unit and its configuration storage
interface cfg_store_if;
    logic       wr_en;  // Store write strobe
    logic [6:0] addr;   // Selected index
    logic [7:0] wdata;  // Byte to store
    logic [7:0] rdata;  // Registered byte at addr

    modport access (output wr_en, output addr, output wdata, input rdata);
    modport store  (input wr_en, input addr, input wdata, output rdata);
endinterface

// ### src/cfg_store.sv
// Generic configuration byte storage with registered read data
module cfg_store
    import cfg_access_pkg::*;
#(
    parameter int DEPTH = CONFIG_SPACE_DEPTH
) (
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  sys_rst,
    // Access side
    cfg_store_if.store bus
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DEPTH < CONFIG_SPACE_DEPTH || DEPTH > 128) begin : g_bad_depth
        $error("cfg_store depth must cover the index space and fit 7 bits");
    end

    logic [7:0] mem      [DEPTH];  // Stored bytes
    logic [7:0] next_mem [DEPTH];  // Next stored bytes
    logic [7:0] next_rdata;        // Next read byte

    // Write decode and read select
    always_comb begin
        next_mem = mem;
        if (bus.wr_en && int'(bus.addr) < DEPTH) begin
            next_mem[bus.addr] = bus.wdata;
        end
        next_rdata = (int'(bus.addr) < DEPTH) ? mem[bus.addr] : 8'h00;
    end

    // Storage registers, cleared only by the cold reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= 8'h00;
            end
            bus.rdata <= 8'h00;
        end else begin
            mem       <= next_mem;
            bus.rdata <= next_rdata;
        end
    end

endmodule // cfg_store

// ### src/key_matcher.sv
// Entry and exit sequencer of extended function mode
module key_matcher
    import cfg_access_pkg::*;
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Port activity
    input  wire logic       key_port_wr,
    input  wire logic       other_wr,
    input  wire logic [7:0] wr_data,
    // Selection
    input  wire logic       key_select,
    input  wire logic       alt_port,
    // Mode
    output logic            ext_mode
);

    key_state_t state;       // Current state
    key_state_t next_state;  // Next state
    logic [7:0] key;         // Entry key in force

    // Next state of the entry sequence
    always_comb begin
        if (alt_port) begin
            key = key_select ? ALT_KEY_HIGH : ALT_KEY_LOW;
        end else begin
            key = key_select ? PRIMARY_KEY_HIGH : PRIMARY_KEY_LOW;
        end
        next_state = state;
        case (state)
            KEY_IDLE: begin
                if (key_port_wr && wr_data == key) begin
                    next_state = alt_port ? KEY_HALF : KEY_EXT;
                end
            end
            KEY_HALF: begin
                if (key_port_wr) begin
                    next_state = (wr_data == key) ? KEY_EXT : KEY_IDLE;
                end else if (other_wr || !alt_port) begin
                    next_state = KEY_IDLE;
                end
            end
            KEY_EXT: begin
                if (key_port_wr && !alt_port && wr_data != key) begin
                    next_state = KEY_IDLE;
                end else if (key_port_wr && alt_port && wr_data == ALT_EXIT_KEY) begin
                    next_state = KEY_IDLE;
                end
            end
            default: next_state = KEY_IDLE;
        endcase
    end

    // State and mode registers
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state    <= KEY_IDLE;
            ext_mode <= 1'b0;
        end else begin
            state    <= next_state;
            ext_mode <= (next_state == KEY_EXT);
        end
    end

endmodule // key_matcher

// ### testbench/cfg_access_sva.sv
// Port-level checker of the configuration access unit
module cfg_access_sva (
    // Clock, reset and host bus
    input wire logic       clock, sys_rst, io_wr, io_rd, io_data_oe,
    input wire logic [9:0] io_addr,
    // Mode and control outputs
    input wire logic       extended_mode, config_lock, immediate_powerdown, floppy_drive_swap,
    input wire logic       external_floppy_ctrl_mode, dual_external_floppy_mode,
    input wire logic       parport_mode_reserved, epp_version_select,
    input wire logic [2:0] parport_mode,
    input wire logic [3:0] uart_a_clock_divisor, uart_b_clock_divisor
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    a_fdc_decode: assert property (external_floppy_ctrl_mode == (parport_mode == 3'h1)
        && dual_external_floppy_mode == (parport_mode == 3'h3)) else $error("fdc flag wrong");
    a_mode_reserved: assert property (parport_mode_reserved
        == (parport_mode inside {3'h2, 3'h4})) else $error("reserved flag wrong");
    // Entry lags one cycle, so the mode must be low on two edges
    a_idle_read_mute: assert property (io_rd && !extended_mode ##1 !extended_mode
        |-> ##1 !io_data_oe) else $error("answer outside mode");
    a_keyport_mute: assert property (io_rd && io_addr inside {10'h250, 10'h251, 10'h3f0}
        |-> ##2 !io_data_oe) else $error("key port answered");
    a_answer_cause: assert property (io_data_oe |-> $past(io_rd, 2))
        else $error("answer without read");
    a_reset_values: assert property ($fell(sys_rst) |-> parport_mode == 3'h0
        && epp_version_select && uart_a_clock_divisor == 4'hd) else $error("bad reset value");
    a_ctrl_hold: assert property (!io_wr |=> $stable({config_lock, immediate_powerdown,
        floppy_drive_swap, parport_mode, epp_version_select, uart_b_clock_divisor}))
        else $error("control moved without write");
    a_mode_cause: assert property ($changed(extended_mode) |-> $past(io_wr, 2))
        else $error("mode moved without write");
    c_enter: cover property ($rose(extended_mode));
    c_answer: cover property (io_data_oe);
    c_lock: cover property ($rose(config_lock));
endmodule // cfg_access_sva

bind config_register_access_unit cfg_access_sva chk (.*);

// ### testbench/host_io_model.sv
// Host processor model issuing I/O port writes and reads
module host_io_model (
    // Clock and answer
    input wire logic        clock, io_data_oe,
    input wire logic  [7:0] io_data_out,
    // Requests
    output logic            io_wr, io_rd,
    output logic      [9:0] io_addr,
    output logic      [7:0] io_data_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {io_wr, io_rd, io_addr, io_data_in} = '0;
    // One write; lines scrambled after release so stale data never matches
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clock) #1 {io_addr, io_data_in, io_wr} = {a, d, 1'b1};
        @(posedge clock) #1 {io_addr, io_data_in, io_wr} = {~a, ~d, 1'b0};
    endtask
    // One read; the answer is awaited for at most three edges
    task automatic rd(input logic [9:0] a, output logic [7:0] d, output logic ok);
        {ok, d} = '0;
        @(posedge clock) #1 {io_addr, io_rd} = {a, 1'b1};
        @(posedge clock) #1 {io_addr, io_rd} = {~a, 1'b0};
        for (int i = 0; i < 3 && !ok; i++) begin
            @(posedge clock) #1 if (io_data_oe === 1'b1) {ok, d} = {1'b1, io_data_out};
        end
    endtask
endmodule // host_io_model

// ### testbench/test_config_register_access_unit.sv
// Self-checking bench of the configuration register access unit
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_errors++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module test_config_register_access_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, sys_rst = 1, strap_key_select = 1, strap_alt_port = 0, ok;
    logic io_wr, io_rd, io_data_oe, extended_mode, config_lock, immediate_powerdown;
    logic floppy_drive_swap, external_floppy_ctrl_mode, dual_external_floppy_mode;
    logic parport_mode_reserved, epp_version_select;
    logic [9:0] io_addr, ip = 10'h251, dp = 10'h252;
    logic [7:0] io_data_in, io_data_out, got;
    logic [7:0] msk [4] = '{8'h0d, 8'h80, 8'h00, 8'h33};
    logic [2:0] parport_mode;
    logic [3:0] uart_a_clock_divisor, uart_b_clock_divisor;
    int n_errors = 0, checks_done = 0;
    config_register_access_unit dut (.*);
    host_io_model h (.*);
    initial forever #20 clock = ~clock;
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic setr(input logic [7:0] x, input logic [7:0] v);
        h.wr(ip, x);
        h.wr(dp, v);
    endtask
    // A missing answer ends the run
    task automatic getr(input logic [7:0] x, input logic [7:0] e);
        h.wr(ip, x);
        h.rd(dp, got, ok);
        `CHK({ok, got}, {1'b1, e});
        if (ok !== 1'b1) give_verdict();
    endtask
    task automatic mode(input logic [9:0] a, input logic [7:0] d, input logic e);
        h.wr(a, d);
        repeat (2) @(posedge clock);
        #1 `CHK(extended_mode, e);
    endtask
    initial begin
        repeat (10) @(posedge clock);
        #1 sys_rst = 0;
        `CHK({parport_mode, epp_version_select, uart_a_clock_divisor}, 8'h1d);
        setr(8'h03, 8'h03);
        h.rd(dp, got, ok);
        `CHK({ok, uart_b_clock_divisor}, 5'h0d);
        mode(10'h250, 8'h88, 1'b0);
        mode(10'h250, 8'h89, 1'b1);
        h.rd(ip, got, ok);
        `CHK(ok, 1'b0);
        $display("test entry done");
        getr(8'h03, 8'h30);
        for (int i = 0; i < 4; i++) begin
            setr(i[7:0], 8'hff);
            getr(i[7:0], msk[i]);
        end
        `CHK({immediate_powerdown, floppy_drive_swap, uart_a_clock_divisor, uart_b_clock_divisor}, 10'h3cc);
        setr(8'h00, 8'h00);
        setr(8'h03, 8'h00);
        `CHK({immediate_powerdown, epp_version_select, uart_a_clock_divisor}, 6'h0d);
        for (int c = 0; c < 8; c++) begin
            setr(8'h09, {c[2], 7'h00});
            setr(8'h00, {4'h0, c[1:0], 2'b00});
            `CHK({parport_mode, external_floppy_ctrl_mode, dual_external_floppy_mode, parport_mode_reserved}, {c[2:0], c == 1, c == 3, c == 2 || c == 4});
        end
        setr(8'h1a, 8'h55);
        getr(8'h1a, 8'h00);
        setr(8'h09, 8'h40);
        setr(8'h03, 8'hff);
        `CHK({config_lock, epp_version_select}, 2'b10);
        setr(8'h09, 8'h00);
        `CHK(config_lock, 1'b0);
        mode(10'h250, 8'h12, 1'b0);
        $display("test registers done");
        {strap_key_select, strap_alt_port, sys_rst} = 3'b011;
        repeat (2) @(posedge clock);
        #1 sys_rst = 0;
        {ip, dp} = {10'h3f0, 10'h3f1};
        h.wr(ip, 8'h86);
        h.wr(dp, 8'h00);
        mode(ip, 8'h86, 1'b0);
        mode(ip, 8'h86, 1'b1);
        getr(8'h03, 8'h30);
        mode(ip, 8'h88, 1'b1);
        mode(ip, 8'haa, 1'b0);
        $display("test alternate done");
        give_verdict();
    end
    initial begin
        #1000000;
        n_errors++;
        give_verdict();
    end
endmodule // test_config_register_access_unit
